// *** hdl/vbs_slave.sv ***
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
// Contract
// - Slave only; standard and fast rates
// - High-speed rate not a specified capability
// - Master makes clock and sends address
// - Master makes start and stop
// - Start, address, data bytes, stop
// - Lines only pulled low or released
// - Idle: both lines released and high
// - Slave transfers only when master commands
// - Separate storage for each channel
// - Four input coupling modes per channel
// - Strap picks off or monitor-bias start
// - Mux source pin picks serial or pin
// - Serial input selection held per channel
// - Address 01011 plus live select pins
// - Subaddress byte then data byte
// - Strap state kept until first write
// - Selector pin low A, high B
module vbs_slave (
  // System side
  input wire logic clk_i,
  input wire logic rst_i,
  // Link side
  input wire logic link_clk_i,
  vbs_link_if.slave bus,
  // Straps and pins
  input wire logic power_up_state_strap_i,
  input wire logic address_select_high_i,
  input wire logic address_select_low_i,
  input wire logic mux_source_i,
  input wire logic mux_selector_i,
  // Channel configuration
  output logic [2:0] chan_input_b_o,
  output logic [5:0] chan_mode_o,
  output logic [2:0] chan_buffer_en_o,
  output logic [2:0] chan_monitor_en_o,
  output logic hsync_en_o,
  output logic vsync_en_o
);
  logic [1:0] lrst_sync;
  logic lrst;
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic scl_d;
  logic sda_d;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  vbs_pkg::vbs_sstate_t state;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] sub_reg;
  logic [7:0] data_reg;
  logic [7:0] rd_byte;
  logic [7:0] rd_val;
  logic [2:0] sub_idx;
  logic rw;
  logic sda_oe;
  logic wr_pending;
  logic written;
  logic commit;
  logic [31:0] cfg_l;
  logic [31:0] next_cfg;
  logic upd_tgl;
  logic [2:0] tgl_sync;
  logic [31:0] cfg_s;
  logic [1:0] mux_meta;
  logic [1:0] mux_sync;

  // Reset level carried into the link domain
  always_ff @(posedge link_clk_i) begin
    lrst_sync <= {lrst_sync[0], rst_i};
  end
  assign lrst = lrst_sync[1];

  // Bus lines and pins pass two flip-flops; address pins stay live
  always_ff @(posedge link_clk_i) begin
    pin_meta <= {bus.scl, bus.sda, address_select_high_i, address_select_low_i, power_up_state_strap_i};
    pin_sync <= pin_meta;
  end
  assign scl_s = pin_sync[4];
  assign sda_s = pin_sync[3];

  // Previous line levels for edge and condition detection
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // Subaddress to storage index and read-back value
  assign sub_idx = sub_reg[2:0] - 3'h1;
  assign rd_val = (sub_reg >= vbs_pkg::SUB_FIRST && sub_reg <= vbs_pkg::SUB_LAST) ?
                  cfg_l[{sub_idx[1:0], 3'h0} +: 8] : 8'h00;

  // Open drain: output value is always low, only the enable moves
  assign bus.s_sda_out = 1'b0;
  assign bus.s_sda_oe = sda_oe;

  // Byte engine: address, subaddress, data or read byte, each with ack slot
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      state <= vbs_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      sub_reg <= 8'h00;
      data_reg <= 8'h00;
      rd_byte <= 8'h00;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      wr_pending <= 1'b0;
    end else if (start_det) begin
      state <= vbs_pkg::ST_ADDR;
      bit_cnt <= 4'hF;  // Clock fall after start wraps to bit 0
      sda_oe <= 1'b0;
      wr_pending <= 1'b0;
    end else if (stop_det) begin
      state <= vbs_pkg::ST_IDLE;
      sda_oe <= 1'b0;
      wr_pending <= 1'b0;
    end else if (scl_rise && bit_cnt < 4'h8) begin
      shreg <= {shreg[6:0], sda_s};
    end else if (scl_fall && state != vbs_pkg::ST_IDLE && state != vbs_pkg::ST_WAIT) begin
      if (bit_cnt == 4'h7) begin
        bit_cnt <= 4'h8;
        unique case (state)
          vbs_pkg::ST_ADDR: begin
            if (shreg[7:1] == {vbs_pkg::ADDR_PREFIX, pin_sync[2], pin_sync[1]}) begin
              sda_oe <= 1'b1;
              rw <= shreg[0];
            end else begin
              state <= vbs_pkg::ST_WAIT;
            end
          end
          vbs_pkg::ST_SUB: begin
            if (shreg >= vbs_pkg::SUB_FIRST && shreg <= vbs_pkg::SUB_LAST) begin
              sub_reg <= shreg;
              sda_oe <= 1'b1;
            end else begin
              state <= vbs_pkg::ST_WAIT;
            end
          end
          vbs_pkg::ST_DATA: begin
            data_reg <= shreg;
            sda_oe <= 1'b1;
            wr_pending <= 1'b1;
          end
          vbs_pkg::ST_READ: sda_oe <= 1'b0;  // Master's ack slot
          default: state <= vbs_pkg::ST_WAIT;
        endcase
      end else if (bit_cnt == 4'h8) begin
        bit_cnt <= 4'h0;
        sda_oe <= 1'b0;
        unique case (state)
          vbs_pkg::ST_ADDR: begin
            if (rw) begin
              state <= vbs_pkg::ST_READ;
              sda_oe <= ~rd_val[7];
              rd_byte <= {rd_val[6:0], 1'b0};
            end else begin
              state <= vbs_pkg::ST_SUB;
            end
          end
          vbs_pkg::ST_SUB: state <= vbs_pkg::ST_DATA;
          default: state <= vbs_pkg::ST_WAIT;  // One byte per transfer
        endcase
      end else begin
        bit_cnt <= bit_cnt + 4'h1;
        if (state == vbs_pkg::ST_READ) begin
          sda_oe <= ~rd_byte[7];
          rd_byte <= {rd_byte[6:0], 1'b0};
        end
      end
    end
  end

  // A write takes effect only at the stop closing a full sequence
  assign commit = stop_det & wr_pending;

  // Strap sets storage until the first write; then only writes change it
  always_comb begin
    next_cfg = cfg_l;
    if (!written) begin
      next_cfg = pin_sync[0] ? vbs_pkg::CFG_STRAP_ON : vbs_pkg::CFG_OFF;
    end
    if (commit) begin
      next_cfg[{sub_idx[1:0], 3'h0} +: 8] = data_reg;
    end
  end

  // Separate byte per channel and a toggle on every change
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      cfg_l <= vbs_pkg::CFG_OFF;
      written <= 1'b0;
      upd_tgl <= 1'b0;
    end else begin
      cfg_l <= next_cfg;
      if (commit) begin
        written <= 1'b1;
      end
      if (next_cfg != cfg_l) begin
        upd_tgl <= ~upd_tgl;
      end
    end
  end

  // Toggle crosses to the system clock; word is stable when seen
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tgl_sync <= 3'h0;
      cfg_s <= vbs_pkg::CFG_OFF;
    end else begin
      tgl_sync <= {tgl_sync[1:0], upd_tgl};
      if (tgl_sync[2] != tgl_sync[1]) begin
        cfg_s <= cfg_l;
      end
    end
  end

  // Mux pins pass two flip-flops
  always_ff @(posedge clk_i) begin
    mux_meta <= {mux_source_i, mux_selector_i};
    mux_sync <= mux_meta;
  end

  // Outputs per channel; mux source decides serial or pin selection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_input_b_o <= 3'h0;
      chan_mode_o <= 6'h00;
      chan_buffer_en_o <= 3'h0;
      chan_monitor_en_o <= 3'h0;
      hsync_en_o <= 1'b0;
      vsync_en_o <= 1'b0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        chan_input_b_o[i] <= mux_sync[1] ? cfg_s[8 * i + vbs_pkg::SEL_BIT] : mux_sync[0];
        chan_mode_o[2 * i +: 2] <= cfg_s[8 * i + vbs_pkg::MODE_LSB +: 2];
        chan_buffer_en_o[i] <= cfg_s[8 * i + vbs_pkg::BUF_BIT];
        chan_monitor_en_o[i] <= cfg_s[8 * i + vbs_pkg::MON_BIT];
      end
      hsync_en_o <= cfg_s[24 + vbs_pkg::HSYNC_BIT];
      vsync_en_o <= cfg_s[24 + vbs_pkg::VSYNC_BIT];
    end
  end
endmodule
`default_nettype wire

// *** hdl/vbs_pkg.sv ***
`default_nettype none
package vbs_pkg;
  // Slave address: fixed upper five bits, two pin bits follow
  localparam logic [4:0] ADDR_PREFIX = 5'h0B;
  // Subaddress range: channels 1..3, then the sync enable control
  localparam logic [7:0] SUB_FIRST = 8'h01;
  localparam logic [7:0] SUB_LAST = 8'h04;
  // Channel byte fields
  localparam int MODE_LSB = 0;
  localparam int SEL_BIT = 2;
  localparam int BUF_BIT = 3;
  localparam int MON_BIT = 4;
  // Control byte fields
  localparam int HSYNC_BIT = 0;
  localparam int VSYNC_BIT = 1;
  // Input coupling modes
  typedef enum logic [1:0] {
    VBS_DC = 2'h0,
    VBS_DC_SHIFT = 2'h1,
    VBS_AC_BIAS = 2'h2,
    VBS_AC_CLAMP = 2'h3
  } vbs_mode_t;
  // Power-up values when the strap is high; all zero when low
  localparam logic [7:0] CH_STRAP_ON = 8'h12;
  localparam logic [7:0] CTRL_STRAP_ON = 8'h03;
  localparam logic [31:0] CFG_STRAP_ON = {CTRL_STRAP_ON, CH_STRAP_ON, CH_STRAP_ON, CH_STRAP_ON};
  localparam logic [31:0] CFG_OFF = 32'h0000_0000;
  // Controller registers on the system bus
  localparam logic [3:0] WB_CTRL = 4'h0;
  localparam logic [3:0] WB_STATUS = 4'h4;
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_SUB_LSB = 8;
  localparam int CMD_ASEL_LSB = 16;
  localparam int CMD_READ_BIT = 18;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;
  localparam int STAT_RDATA_LSB = 8;
  // Serial clock timing
  localparam int CLK_KHZ = 100000;
  localparam int SCL_KHZ = 400;
  localparam int QUARTER_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  // Slave states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_SUB = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_WAIT = 6'h20
  } vbs_sstate_t;
  // Master states
  typedef enum logic [3:0] {
    M_IDLE = 4'h1,
    M_START = 4'h2,
    M_BIT = 4'h4,
    M_STOP = 4'h8
  } vbs_mstate_t;
endpackage
`default_nettype wire

// *** hdl/vbs_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface vbs_link_if;
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  logic s_sda_out;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Pull-ups: a line rests high unless an end pulls it low
  assign scl = !(m_scl_oe && !m_scl_out);
  assign sda = !((m_sda_oe && !m_sda_out) || (s_sda_oe && !s_sda_out));
  modport master (output m_scl_out, m_scl_oe, m_sda_out, m_sda_oe, input scl, sda);
  modport slave (output s_sda_out, s_sda_oe, input scl, sda);
endinterface
`default_nettype wire

// *** hdl/vbs_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module vbs_master #(
  parameter int QUARTER = vbs_pkg::QUARTER_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Serial link
  vbs_link_if.master bus
);
  vbs_pkg::vbs_mstate_t mstate;
  logic [23:0] cmd;
  logic [7:0] tcnt;
  logic qtick;
  logic [1:0] ph;
  logic [3:0] bit_cnt;
  logic [1:0] step;
  logic [8:0] tx;
  logic [8:0] rx;
  logic [7:0] cur_byte;
  logic [7:0] rdata;
  logic nack;
  logic scl_oe;
  logic sda_oe;
  logic [1:0] scl_meta;
  logic [1:0] sda_meta;
  logic wb_req;
  logic go;
  logic is_read;
  logic [1:0] asel;

  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign go = wb_req & wb_we_i & wb_sel_i[2] & (wb_adr_i == vbs_pkg::WB_CTRL) & (mstate == vbs_pkg::M_IDLE);
  assign is_read = cmd[vbs_pkg::CMD_READ_BIT];
  assign asel = cmd[vbs_pkg::CMD_ASEL_LSB +: 2];

  // Register access: ack one cycle after the request, unmapped reads zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          vbs_pkg::WB_CTRL: wb_dat_o <= {8'h00, cmd};
          vbs_pkg::WB_STATUS: wb_dat_o <= {16'h0000, rdata, 6'h00, nack, mstate != vbs_pkg::M_IDLE};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Command bytes by lane; ignored while a transfer runs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd <= 24'h00_0000;
    end else if (wb_req && wb_we_i && wb_adr_i == vbs_pkg::WB_CTRL && mstate == vbs_pkg::M_IDLE) begin
      for (int b = 0; b < 3; b++) begin
        if (wb_sel_i[b]) begin
          cmd[8 * b +: 8] <= wb_dat_i[8 * b +: 8];
        end
      end
    end
  end

  // Bus lines pass two flip-flops
  always_ff @(posedge clk_i) begin
    scl_meta <= {scl_meta[0], bus.scl};
    sda_meta <= {sda_meta[0], bus.sda};
  end

  // Quarter-period divider for the serial clock
  assign qtick = (tcnt == 8'(QUARTER - 1));
  always_ff @(posedge clk_i) begin
    if (rst_i || mstate == vbs_pkg::M_IDLE || qtick) begin
      tcnt <= 8'h00;
    end else begin
      tcnt <= tcnt + 8'h01;
    end
  end

  // Byte for each step: address write, subaddress, data or address read, read
  always_comb begin
    case (step)
      2'h0: cur_byte = {vbs_pkg::ADDR_PREFIX, asel, 1'b0};
      2'h1: cur_byte = cmd[vbs_pkg::CMD_SUB_LSB +: 8];
      2'h2: cur_byte = is_read ? {vbs_pkg::ADDR_PREFIX, asel, 1'b1} : cmd[vbs_pkg::CMD_DATA_LSB +: 8];
      default: cur_byte = 8'hFF;  // Released so the slave drives
    endcase
  end

  // Open drain: only the enables move
  assign bus.m_scl_out = 1'b0;
  assign bus.m_sda_out = 1'b0;
  assign bus.m_scl_oe = scl_oe;
  assign bus.m_sda_oe = sda_oe;

  // Transfer sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mstate <= vbs_pkg::M_IDLE;
      ph <= 2'h0;
      bit_cnt <= 4'h0;
      step <= 2'h0;
      tx <= 9'h1FF;
      rx <= 9'h000;
      rdata <= 8'h00;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else if (mstate == vbs_pkg::M_IDLE) begin
      if (go) begin
        mstate <= vbs_pkg::M_START;
        step <= 2'h0;
        ph <= 2'h0;
        nack <= 1'b0;
      end
    end else if (qtick) begin
      unique case (mstate)
        vbs_pkg::M_START: begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: sda_oe <= 1'b0;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b1;
            default: begin
              scl_oe <= 1'b1;
              mstate <= vbs_pkg::M_BIT;
              bit_cnt <= 4'h0;
            end
          endcase
        end
        vbs_pkg::M_BIT: begin
          case (ph)
            2'h0: begin
              ph <= 2'h1;
              if (bit_cnt == 4'h0) begin
                tx <= {cur_byte, 1'b1};
                sda_oe <= ~cur_byte[7];
              end else begin
                sda_oe <= ~tx[8];
              end
            end
            2'h1: begin
              scl_oe <= 1'b0;
              ph <= 2'h2;
            end
            2'h2: begin
              if (scl_meta[1]) begin
                rx <= {rx[7:0], sda_meta[1]};
                ph <= 2'h3;
              end
            end
            default: begin
              scl_oe <= 1'b1;
              tx <= {tx[7:0], 1'b1};
              ph <= 2'h0;
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h8) begin
                bit_cnt <= 4'h0;
                if (step != 2'h3 && rx[0]) begin
                  nack <= 1'b1;
                  mstate <= vbs_pkg::M_STOP;
                end else if (step == 2'h3) begin
                  rdata <= rx[8:1];
                  mstate <= vbs_pkg::M_STOP;
                end else if (!is_read && step == 2'h2) begin
                  mstate <= vbs_pkg::M_STOP;
                end else if (is_read && step == 2'h1) begin
                  step <= 2'h2;
                  mstate <= vbs_pkg::M_START;
                end else begin
                  step <= step + 2'h1;
                end
              end
            end
          endcase
        end
        vbs_pkg::M_STOP: begin
          ph <= ph + 2'h1;
          case (ph)
            2'h0: sda_oe <= 1'b1;
            2'h1: scl_oe <= 1'b0;
            2'h2: sda_oe <= 1'b0;
            default: mstate <= vbs_pkg::M_IDLE;
          endcase
        end
        default: mstate <= vbs_pkg::M_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** bench/vbs_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module vbs_props #(
  parameter int QUARTER = 40
) (
  // Clocks and resets
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_clk_i,
  // Link signals
  input wire logic m_scl_out,
  input wire logic m_scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic in_frame;
  logic [7:0] bit_cnt;
  logic [15:0] hi_cnt;
  logic start_ev;
  logic stop_ev;
  // Start and stop: data edge while the clock line stays high
  assign start_ev = scl && scl_q && sda_q && !sda;
  assign stop_ev = scl && scl_q && !sda_q && sda;
  // Line levels one cycle back
  always_ff @(posedge clk_i) begin
    scl_q <= scl;
    sda_q <= sda;
  end
  // Frame open between start and stop
  always_ff @(posedge clk_i) begin
    if (rst_i) in_frame <= 1'b0;
    else if (start_ev) in_frame <= 1'b1;
    else if (stop_ev) in_frame <= 1'b0;
  end
  // Clock rises since the last start
  always_ff @(posedge clk_i) begin
    if (rst_i || start_ev) bit_cnt <= 8'h00;
    else if (scl && !scl_q) bit_cnt <= bit_cnt + 8'h01;
  end
  // Length of the clock high phase, saturating so idle time cannot wrap
  always_ff @(posedge clk_i) begin
    if (rst_i || !scl) hi_cnt <= 16'h0000;
    else if (hi_cnt != 16'hFFFF) hi_cnt <= hi_cnt + 16'h0001;
  end
  // Bus left free after a stop
  sequence s_released;
    (scl && sda) [*4];
  endsequence
  // Slave holds its low level for eight cycles after a clock rise
  sequence s_hold_low;
    s_sda_oe [*8];
  endsequence
  a_open_drain: assert property (@(posedge clk_i) disable iff (rst_i)
    !m_scl_out && !m_sda_out && !s_sda_out) else $error("line driven high");
  a_clock_by_master: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(scl) |-> in_frame) else $error("clock line moved outside a frame");
  a_idle_at_release: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) |-> scl && sda) else $error("lines not released after reset");
  a_stop_then_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_ev |=> s_released) else $error("lines not free after stop");
  a_start_from_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    start_ev && !in_frame |-> $past(scl, 4) && $past(sda, 4)) else $error("start without idle bus");
  a_byte_framing: assert property (@(posedge clk_i) disable iff (rst_i)
    (start_ev || stop_ev) && in_frame |-> bit_cnt % 9 == 1) else $error("frame not whole bytes");
  a_slave_in_frame: assert property (@(posedge clk_i) disable iff (rst_i)
    s_sda_oe |-> in_frame) else $error("slave drives outside a frame");
  a_slave_clock_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $changed(s_sda_oe) |-> !scl) else $error("slave changed data with clock high");
  a_ack_held: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(scl) && s_sda_oe |=> s_hold_low) else $error("slave low level not held");
  a_clock_high_time: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(scl) |-> hi_cnt >= QUARTER) else $error("clock high phase too short");
endmodule
`default_nettype wire

// *** bench/test_video_buffer_serial_control_slave.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_video_buffer_serial_control_slave;
  localparam int QTR = 40;
  logic clk_i = 1'b0;
  logic link_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap, msrc, msel, cyc, stb, we, ack, watch, committed, hs, vs;
  logic [1:0] pins;
  logic [3:0] adr;
  logic [31:0] dat, rdata;
  logic [2:0] in_b, buf_en, mon_en;
  logic [5:0] mode;
  logic [7:0] ch [1:4];
  logic [16:0] exp_cfg, last_cfg;
  logic [16:0] cfg_q[$];
  logic [31:0] stat_q[$];
  int failures, total_checks, cycles;
  wire [16:0] cfg = {vs, hs, mon_en, buf_en, mode, in_b};
  // System clock and an unrelated link clock
  always #5 clk_i = ~clk_i;
  initial begin
    #3;
    forever #16 link_clk_i = ~link_clk_i;
  end
  vbs_link_if lnk();
  vbs_master #(.QUARTER(QTR)) i_vbs_master (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack), .bus(lnk));
  vbs_slave i_vbs_slave (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i), .bus(lnk),
    .power_up_state_strap_i(strap), .address_select_high_i(pins[1]), .address_select_low_i(pins[0]),
    .mux_source_i(msrc), .mux_selector_i(msel), .chan_input_b_o(in_b), .chan_mode_o(mode),
    .chan_buffer_en_o(buf_en), .chan_monitor_en_o(mon_en), .hsync_en_o(hs), .vsync_en_o(vs));
  vbs_props #(.QUARTER(QTR)) i_vbs_props (.clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .m_scl_out(lnk.m_scl_out), .m_scl_oe(lnk.m_scl_oe), .m_sda_out(lnk.m_sda_out), .m_sda_oe(lnk.m_sda_oe),
    .s_sda_out(lnk.s_sda_out), .s_sda_oe(lnk.s_sda_oe), .scl(lnk.scl), .sda(lnk.sda));
  // Expected outputs from the stored bytes, strap and mux pins
  function automatic logic [16:0] model();
    logic [7:0] b;
    logic [16:0] r;
    r = '0;
    for (int c = 1; c <= 3; c++) begin
      b = committed ? ch[c] : (strap ? vbs_pkg::CH_STRAP_ON : 8'h00);
      r[c - 1] = msrc ? b[vbs_pkg::SEL_BIT] : msel;
      r[2 * c + 1 +: 2] = b[vbs_pkg::MODE_LSB +: 2];
      r[8 + c] = b[vbs_pkg::BUF_BIT];
      r[11 + c] = b[vbs_pkg::MON_BIT];
    end
    b = committed ? ch[4] : (strap ? vbs_pkg::CTRL_STRAP_ON : 8'h00);
    r[15] = b[vbs_pkg::HSYNC_BIT];
    r[16] = b[vbs_pkg::VSYNC_BIT];
    return r;
  endfunction
  // Queue a note only when the outputs should move
  task automatic note();
    logic [16:0] n;
    n = model();
    if (n !== exp_cfg) begin
      cfg_q.push_back(n);
      exp_cfg = n;
    end
  endtask
  task automatic cmp_cfg(input logic [16:0] e, input logic [16:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value cfg expected %h seen %h", e, s);
    end
  endtask
  task automatic cmp_stat(input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value status expected %h seen %h", e, s);
    end
  endtask
  // One classic bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic chk,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    watch <= chk;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) failures++;
    q = rdata;
    cyc <= 1'b0;
    stb <= 1'b0;
    watch <= 1'b0;
  endtask
  // Start a link transfer, wait for idle, then check the final status
  task automatic xfer(input logic rd, input logic [1:0] as, input logic [7:0] sub, input logic [7:0] d,
                      input logic [31:0] es);
    logic [31:0] q;
    int n;
    n = 0;
    wb(1'b1, vbs_pkg::WB_CTRL, {13'h0, rd, as, sub, d}, 1'b0, q);
    do begin
      wb(1'b0, vbs_pkg::WB_STATUS, 32'h0, 1'b0, q);
      n++;
    end while (q[vbs_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 5000);
    if (q[vbs_pkg::STAT_BUSY_BIT] !== 1'b0) failures++;
    stat_q.push_back(es);
    wb(1'b0, vbs_pkg::WB_STATUS, 32'h0, 1'b1, q);
  endtask
  task automatic wr(input logic [1:0] as, input logic [7:0] sub, input logic [7:0] d, input logic ok);
    if (ok && !committed) begin
      for (int c = 1; c <= 4; c++) ch[c] = (c == 4) ? (strap ? vbs_pkg::CTRL_STRAP_ON : 8'h00)
                                                    : (strap ? vbs_pkg::CH_STRAP_ON : 8'h00);
      committed = 1'b1;
    end
    if (ok) ch[sub[2:0]] = d;
    note();
    xfer(1'b0, as, sub, d, {30'h0, !ok, 1'b0});
  endtask
  // Strap, address pins and mux pins together
  task automatic pins_to(input logic [4:0] v);
    @(posedge clk_i);
    {strap, pins, msrc, msel} <= v;
    @(posedge clk_i);
    note();
    repeat (60) @(posedge clk_i);
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watcher: compares each output change and each marked status read
  always @(posedge clk_i) begin
    cycles++;
    if (rst_i) last_cfg <= '0;
    else if (cfg !== last_cfg) begin
      last_cfg <= cfg;
      cmp_cfg(cfg_q.size() > 0 ? cfg_q.pop_front() : 17'h1FFFF, cfg);
    end
    if (ack === 1'b1 && watch) cmp_stat(stat_q.pop_front(), rdata);
    if (cycles == 95000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    logic [31:0] q;
    void'($urandom(32'h4657));
    {strap, pins, msrc, msel} = 5'b1_10_1_0;
    {cyc, stb, we, watch, committed} = 5'h00;
    adr = 4'h0;
    dat = 32'h0;
    exp_cfg = 17'h0;
    note();
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (60) @(posedge clk_i);
    pins_to(5'b0_10_1_0);
    pins_to(5'b1_10_1_0);
    wr(2'b01, 8'h01, 8'h05, 1'b0);
    wr(2'b10, 8'h00, 8'h07, 1'b0);
    wr(2'b10, 8'h05, 8'h07, 1'b0);
    for (int i = 0; i < 4; i++) wr(2'b10, 8'(i % 3 + 1), {3'h0, 3'($urandom), 2'(i)}, 1'b1);
    wr(2'b10, 8'h04, 8'h02, 1'b1);
    pins_to(5'b0_10_1_0);
    pins_to(5'b0_01_1_0);
    wr(2'b01, 8'h02, 8'h1F, 1'b1);
    wr(2'b10, 8'h02, 8'h00, 1'b0);
    pins_to(5'b0_01_0_0);
    pins_to(5'b0_01_0_1);
    pins_to(5'b0_01_1_1);
    xfer(1'b1, 2'b01, 8'h02, 8'h00, {16'h0, ch[2], 8'h00});
    wb(1'b1, 4'hC, 32'hFFFF_FFFF, 1'b0, q);
    stat_q.push_back(32'h0);
    wb(1'b0, 4'hC, 32'h0, 1'b1, q);
    repeat (100) @(posedge clk_i);
    cmp_stat(32'h0, 32'(cfg_q.size() + stat_q.size()));
    report_and_stop();
  end
endmodule
`default_nettype wire
